// file: logic/cpudec_pkg.sv
// shared constants and types for the opcode decode block
package cpudec_pkg;

	// ----------------------------------------------------------------
	// opcode values with special handling
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_PAGE2 = 8'h10;
	localparam logic [7:0] OP_PAGE3 = 8'h11;
	localparam logic [7:0] OP_LONG_ALWAYS = 8'h16;
	localparam logic [7:0] OP_LONG_CALL = 8'h17;
	localparam logic [7:0] OP_SIGN_EXT = 8'h1d;
	localparam logic [7:0] OP_XCHG = 8'h1e;
	localparam logic [7:0] OP_XFER = 8'h1f;
	localparam logic [7:0] OP_BR_ALWAYS = 8'h20;
	localparam logic [7:0] OP_BR_NEVER = 8'h21;
	localparam logic [7:0] OP_PUSH_HW = 8'h34;
	localparam logic [7:0] OP_PULL_USR = 8'h37;
	localparam logic [7:0] OP_UMULT = 8'h3d;
	localparam logic [7:0] OP_SOFT_INT = 8'h3f;
	localparam logic [3:0] ROW_RMW_DIR = 4'h0;
	localparam logic [3:0] ROW_MISC = 4'h1;
	localparam logic [3:0] ROW_BRANCH = 4'h2;
	localparam logic [3:0] ROW_STACK = 4'h3;
	localparam logic [3:0] ROW_INH_A = 4'h4;
	localparam logic [3:0] ROW_INH_B = 4'h5;
	localparam logic [3:0] ROW_RMW_IDX = 4'h6;
	localparam logic [3:0] ROW_RMW_EXT = 4'h7;
	localparam logic [3:0] LO_NEGATE = 4'h0;
	localparam logic [3:0] LO_SBC = 4'h2;
	localparam logic [3:0] LO_W16 = 4'h3;
	localparam logic [3:0] LO_STORE8 = 4'h7;
	localparam logic [3:0] LO_CMP_LD = 4'hc;
	localparam logic [3:0] LO_CALL = 4'hd;
	localparam logic [3:0] LO_LD16 = 4'he;
	localparam logic [3:0] LO_ST16 = 4'hf;
	localparam logic [3:0] LO_JUMP = 4'he;
	// unused positions in the memory and inherent rows, one bit per nibble
	localparam logic [15:0] RMW_HOLES = 16'h0826;
	localparam logic [15:0] INH_HOLES = 16'h4826;
	// register pair codes for transfer and exchange
	localparam logic [3:0] PAIR_W16_MAX = 4'h5;
	localparam logic [3:0] PAIR_W8_MIN = 4'h8;
	localparam logic [3:0] PAIR_W8_MAX = 4'hb;
	localparam int STACK_W16_LSB = 4;
	localparam logic [15:0] DEAD_ADDR = 16'hffff;
	localparam int CC_C = 0;
	localparam int CC_V = 1;
	localparam int CC_Z = 2;
	localparam int CC_N = 3;

	// ----------------------------------------------------------------
	// base cycle counts and byte lengths
	// ----------------------------------------------------------------
	localparam int CYC_W = 6;
	localparam int LEN_W = 4;
	localparam logic [4:0] CYC_INH = 5'h02;
	localparam logic [4:0] CYC_SYNC = 5'h04;
	localparam logic [4:0] CYC_CC_IMM = 5'h03;
	localparam logic [4:0] CYC_XCHG = 5'h08;
	localparam logic [4:0] CYC_XFER = 5'h06;
	localparam logic [4:0] CYC_SHORT_BR = 5'h03;
	localparam logic [4:0] CYC_LONG_BR = 5'h05;
	localparam logic [4:0] CYC_TAKEN_ADD = 5'h01;
	localparam logic [4:0] CYC_SHORT_CALL = 5'h07;
	localparam logic [4:0] CYC_LONG_CALL = 5'h09;
	localparam logic [4:0] CYC_LEA = 5'h04;
	localparam logic [4:0] CYC_STACK = 5'h05;
	localparam logic [4:0] CYC_RET_SUB = 5'h05;
	localparam logic [4:0] CYC_ADD_X = 5'h03;
	localparam logic [4:0] CYC_RET_INT = 5'h06;
	localparam logic [4:0] CYC_WAIT_INT = 5'h14;
	localparam logic [4:0] CYC_UMULT = 5'h0b;
	localparam logic [4:0] CYC_SOFT1 = 5'h13;
	localparam logic [4:0] CYC_SOFT23 = 5'h14;
	localparam logic [4:0] CYC_RMW_DIR = 5'h06;
	localparam logic [4:0] CYC_RMW_IDX = 5'h06;
	localparam logic [4:0] CYC_RMW_EXT = 5'h07;
	localparam logic [4:0] CYC_JMP_DIR = 5'h03;
	localparam logic [4:0] CYC_JMP_EXT = 5'h04;
	localparam logic [4:0] CYC_PAGE_ADD = 5'h01;
	localparam logic [19:0] CYC_A8 = 20'h22445;
	localparam logic [19:0] CYC_W16 = 20'h46667;
	localparam logic [19:0] CYC_LD16 = 20'h35556;
	localparam logic [19:0] CYC_CALL = 20'h07778;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [3:0] LEN_TWO = 4'h2;
	localparam logic [3:0] LEN_THREE = 4'h3;
	localparam logic [3:0] LEN_LONG_BR = 4'h4;
	localparam logic [3:0] LEN_PAGE_ADD = 4'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OP1 = 3'b001,
		ST_PG2 = 3'b010,
		ST_PG3 = 3'b100
	} cpudec_st_t;

	typedef enum logic [2:0] {
		MD_INH = 3'h0,
		MD_IMM = 3'h1,
		MD_DIR = 3'h2,
		MD_IDX = 3'h3,
		MD_EXT = 3'h4,
		MD_REL = 3'h5
	} cpudec_mode_t;

	typedef struct packed {
		logic legal;
		logic wide;
		cpudec_mode_t mode;
		logic [4:0] cyc;
		logic [3:0] len;
	} cpudec_info_t;

	typedef struct packed {
		cpudec_st_t st;
		logic dec_valid;
		logic illegal;
		logic prefix;
		cpudec_mode_t mode;
		logic [CYC_W-1:0] cycles;
		logic [LEN_W-1:0] len;
		logic [4:0] base_cyc;
		logic branch;
		logic taken;
		logic long_br;
		logic stack_op;
		logic stack_push;
		logic stack_user;
		logic set_masks;
		logic h_undef;
		logic pair_bad;
		logic res_valid;
		logic [15:0] res_d;
		logic res_carry;
		logic fetch_next;
		logic [15:0] bus_addr;
		logic bus_rw;
		logic bus_status;
	} cpudec_state_t;

endpackage

// file: logic/cpudec_cond_if.sv
// branch condition request between decoder and evaluator
`timescale 1ns/1ps
interface cpudec_cond_if;
	logic [3:0] sel;
	logic [7:0] flags;
	logic taken;
	modport req (output sel, output flags, input taken);
	modport eval (input sel, input flags, output taken);
endinterface

// file: logic/cpudec_branch_eval.sv
// branch condition evaluator for the sixteen relative tests
`timescale 1ns/1ps
module cpudec_branch_eval
	import cpudec_pkg::*;
(
	// condition request
	cpudec_cond_if.eval cif
);

	logic c;
	logic v;
	logic z;
	logic n;
	logic base;

	assign c = cif.flags[CC_C];
	assign v = cif.flags[CC_V];
	assign z = cif.flags[CC_Z];
	assign n = cif.flags[CC_N];

	// even code holds the test, odd code its complement
	always_comb begin
		case (cif.sel[3:1])
			3'h0: base = 1'b1;
			3'h1: base = ~(c | z); // RULE_13
			3'h2: base = ~c; // RULE_12
			3'h3: base = ~z;
			3'h4: base = ~v;
			3'h5: base = ~n;
			3'h6: base = (n == v); // RULE_22
			3'h7: base = ~z & (n == v); // RULE_22
			default: base = 1'b0;
		endcase
		cif.taken = base ^ cif.sel[0];
	end

endmodule

// file: logic/cpudec_top.sv
// opcode decode, cycle count and special result logic of the core
//
// Overview of operation
// RULE_01 - unused opcode positions decode as illegal and raise the flag
// RULE_02 - bytes 10 and 11 only select the second or third page
// RULE_03 - indexed counts are bases; postbyte extra cycles and bytes add on
// RULE_04 - stack push and pull take five cycles plus one per byte moved
// RULE_05 - 34 pushes to hardware stack, 36 to user stack, two bytes
// RULE_06 - 35 pulls from hardware stack, 37 from user stack, two bytes
// RULE_07 - long conditional branch: prefix, short opcode, 16-bit offset
// RULE_08 - long conditional branch: four bytes, six cycles taken, five not
// RULE_09 - short branch: two bytes, three cycles taken or not
// RULE_10 - every branch test has short and long forms, same condition
// RULE_11 - short call 8D two bytes seven cycles; long call 17 three nine
// RULE_12 - opcode 24 is unsigned higher-or-same, taken when carry clear
// RULE_13 - 23 taken on carry or zero; 22 is its complement
// RULE_14 - 3D: unsigned A times B into 16 bits, eleven cycles, one byte
// RULE_15 - multiply carry equals bit seven of the product low byte
// RULE_16 - negate and subtract leave the half-carry flag undefined
// RULE_17 - transfer and exchange accept only same-size 8 or 16 bit pairs
// RULE_18 - first soft interrupt sets both masks; second and third leave them
// RULE_19 - 1D copies bit seven of low accumulator to all high bits
// RULE_20 - next program byte is always fetched while decoding the opcode
// RULE_21 - dead bus cycle drives address FFFF, read high, bus status low
// RULE_22 - signed tests use sign, overflow and zero flags
// RULE_23 - each valid opcode yields mode, byte length and base cycle count
`timescale 1ns/1ps
module cpudec_top
	import cpudec_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// fetch sequencer
	input wire logic op_valid_i,
	input wire logic [7:0] op_byte_i,
	input wire logic [7:0] post_byte_i,
	input wire logic [3:0] idx_extra_cyc_i,
	input wire logic [3:0] idx_extra_len_i,
	// datapath state
	input wire logic [7:0] cond_code_reg_i,
	input wire logic [7:0] acc_a_i,
	input wire logic [7:0] acc_b_i,
	// bus cycle request
	input wire logic dead_bus_cycle_i,
	input wire logic [15:0] fetch_addr_i,
	input wire logic bus_status_line_i,
	// decode results
	output logic dec_valid_o,
	output logic illegal_o,
	output logic prefix_o,
	output cpudec_mode_t mode_o,
	output logic [LEN_W-1:0] total_len_o,
	output logic [CYC_W-1:0] total_cycles_o,
	output logic [4:0] base_cycles_o,
	output logic branch_o,
	output logic branch_taken_o,
	output logic long_branch_o,
	output logic stack_op_o,
	output logic stack_push_o,
	output logic stack_user_o,
	output logic set_irq_masks_o,
	output logic half_carry_undef_o,
	output logic reg_pair_bad_o,
	// special results
	output logic result_valid_o,
	output logic [15:0] result_d_o,
	output logic result_carry_o,
	// bus
	output logic fetch_next_o,
	output logic [15:0] bus_addr_o,
	output logic bus_rw_o,
	output logic bus_status_line_o
);

	// ----------------------------------------------------------------
	// lookup helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] pick(input logic [1:0] md,
		input logic [19:0] tbl);
		logic [3:0] v;
		// immediate in the top nibble, then direct, indexed, extended in the low three nibbles; bits 15:12 unused
		if (md == 2'h0)
			v = tbl[19:16];
		else
			v = tbl[(3 - md) * 4 +: 4];
		pick = {1'b0, v};
	endfunction

	function automatic cpudec_info_t acc_lookup(input logic [7:0] op);
		cpudec_info_t r;
		logic [1:0] md;
		logic side_b;
		md = op[5:4];
		side_b = op[6];
		r.legal = 1'b1;
		r.wide = 1'b0;
		case (md)
			2'h0: r.mode = MD_IMM;
			2'h1: r.mode = MD_DIR;
			2'h2: r.mode = MD_IDX;
			default: r.mode = MD_EXT;
		endcase
		r.len = (md == 2'h3) ? LEN_THREE : LEN_TWO;
		r.cyc = pick(md, CYC_A8);
		case (op[3:0])
			LO_W16: begin
				r.wide = 1'b1;
				r.cyc = pick(md, CYC_W16);
			end
			LO_CMP_LD: begin
				r.wide = 1'b1;
				r.cyc = side_b ? pick(md, CYC_LD16) : pick(md, CYC_W16);
			end
			LO_LD16: begin
				r.wide = 1'b1;
				r.cyc = pick(md, CYC_LD16);
			end
			LO_CALL: begin
				r.wide = 1'b1;
				r.legal = ~(side_b & (md == 2'h0));
				r.cyc = side_b ? pick(md, CYC_LD16) : pick(md, CYC_CALL);
				if (!side_b && md == 2'h0) begin
					r.mode = MD_REL; // RULE_11
					r.cyc = CYC_SHORT_CALL;
				end
			end
			LO_ST16: begin
				r.wide = 1'b1;
				r.legal = (md != 2'h0); // RULE_01
				r.cyc = pick(md, CYC_LD16);
			end
			LO_STORE8: r.legal = (md != 2'h0); // RULE_01
			default: r.legal = 1'b1;
		endcase
		if (r.wide && md == 2'h0 && op[3:0] != LO_CALL)
			r.len = LEN_THREE;
		return r;
	endfunction

	function automatic cpudec_info_t lookup_p1(input logic [7:0] op);
		cpudec_info_t r;
		logic [3:0] lo;
		lo = op[3:0];
		r = '{legal: 1'b1, wide: 1'b0, mode: MD_INH, cyc: CYC_INH,
			len: LEN_ONE};
		if (op[7]) begin
			r = acc_lookup(op);
		end else begin
			case (op[7:4])
				ROW_RMW_DIR, ROW_RMW_IDX, ROW_RMW_EXT: begin
					r.legal = ~RMW_HOLES[lo]; // RULE_01
					r.mode = (op[7:4] == ROW_RMW_DIR) ? MD_DIR :
						(op[7:4] == ROW_RMW_IDX) ? MD_IDX : MD_EXT;
					r.len = (r.mode == MD_EXT) ? LEN_THREE : LEN_TWO;
					r.cyc = (r.mode == MD_DIR) ? CYC_RMW_DIR :
						(r.mode == MD_IDX) ? CYC_RMW_IDX : CYC_RMW_EXT;
					if (lo == LO_JUMP)
						r.cyc = (r.mode == MD_EXT) ? CYC_JMP_EXT : CYC_JMP_DIR;
				end
				ROW_INH_A, ROW_INH_B: r.legal = ~INH_HOLES[lo]; // RULE_01
				ROW_BRANCH: begin
					r.mode = MD_REL; // RULE_09
					r.cyc = CYC_SHORT_BR;
					r.len = LEN_TWO;
				end
				ROW_STACK: begin
					if (lo < 4'h4) begin
						r.mode = MD_IDX;
						r.cyc = CYC_LEA;
						r.len = LEN_TWO;
					end else if (lo < 4'h8) begin
						r.cyc = CYC_STACK; // RULE_05 RULE_06
						r.len = LEN_TWO;
					end else begin
						case (op)
							8'h39: r.cyc = CYC_RET_SUB;
							8'h3a: r.cyc = CYC_ADD_X;
							8'h3b: r.cyc = CYC_RET_INT;
							8'h3c: begin
								r.mode = MD_IMM;
								r.cyc = CYC_WAIT_INT;
								r.len = LEN_TWO;
							end
							OP_UMULT: r.cyc = CYC_UMULT; // RULE_14
							OP_SOFT_INT: r.cyc = CYC_SOFT1;
							default: r.legal = 1'b0; // RULE_01
						endcase
					end
				end
				default: begin
					case (op)
						8'h12, 8'h19, OP_SIGN_EXT: r.cyc = CYC_INH; // RULE_19
						8'h13: r.cyc = CYC_SYNC;
						OP_LONG_ALWAYS, OP_LONG_CALL: begin
							r.mode = MD_REL;
							r.len = LEN_THREE;
							r.cyc = (op == OP_LONG_CALL) ? CYC_LONG_CALL :
								CYC_LONG_BR; // RULE_11
						end
						8'h1a, 8'h1c: begin
							r.mode = MD_IMM;
							r.cyc = CYC_CC_IMM;
							r.len = LEN_TWO;
						end
						OP_XCHG, OP_XFER: begin
							r.cyc = (op == OP_XCHG) ? CYC_XCHG : CYC_XFER;
							r.len = LEN_TWO;
						end
						default: r.legal = 1'b0; // RULE_01
					endcase
				end
			endcase
		end
		return r;
	endfunction

	function automatic cpudec_info_t lookup_pg(input logic page3,
		input logic [7:0] op);
		cpudec_info_t r;
		logic a_side;
		logic [3:0] lo;
		lo = op[3:0];
		a_side = ~op[6];
		r = acc_lookup(op);
		if (!page3 && op[7:4] == ROW_BRANCH && op != OP_BR_ALWAYS) begin
			r.legal = 1'b1; // RULE_07 RULE_10
			r.mode = MD_REL;
			r.cyc = CYC_LONG_BR;
			r.len = LEN_LONG_BR; // RULE_08
		end else if (op == OP_SOFT_INT) begin
			r.legal = 1'b1;
			r.mode = MD_INH;
			r.cyc = CYC_SOFT23;
			r.len = LEN_TWO;
		end else if (op[7]) begin
			if (page3)
				r.legal = a_side & (lo == LO_W16 || lo == LO_CMP_LD);
			else
				r.legal = r.legal & ((a_side & (lo == LO_W16 ||
					lo == LO_CMP_LD)) || lo == LO_LD16 || lo == LO_ST16);
			r.cyc = r.cyc + CYC_PAGE_ADD;
			r.len = r.len + LEN_PAGE_ADD;
		end else begin
			r.legal = 1'b0; // RULE_01
		end
		return r;
	endfunction

	function automatic logic [3:0] stack_bytes(input logic [7:0] sel);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			if (sel[i])
				n = n + ((i >= STACK_W16_LSB) ? 4'h2 : 4'h1);
		return n;
	endfunction

	function automatic logic [1:0] pair_class(input logic [3:0] code);
		if (code <= PAIR_W16_MAX)
			pair_class = 2'h1;
		else if (code >= PAIR_W8_MIN && code <= PAIR_W8_MAX)
			pair_class = 2'h2;
		else
			pair_class = 2'h0;
	endfunction

	// ----------------------------------------------------------------
	// branch condition evaluator
	// ----------------------------------------------------------------
	cpudec_cond_if cif ();
	cpudec_branch_eval u_eval (
		.cif(cif)
	);
	assign cif.sel = op_byte_i[3:0];
	assign cif.flags = cond_code_reg_i;

	// ----------------------------------------------------------------
	// decode state
	// ----------------------------------------------------------------
	cpudec_state_t cur_reg;
	cpudec_state_t cur_next;

	always_comb begin
		cpudec_info_t info;
		logic paged;
		logic [15:0] prod;
		logic [CYC_W-1:0] add;
		info = '{legal: 1'b0, wide: 1'b0, mode: MD_INH, cyc: 5'h00,
			len: 4'h0};
		paged = 1'b0;
		prod = acc_a_i * acc_b_i; // RULE_14
		add = '0;
		cur_next = cur_reg;
		cur_next.dec_valid = 1'b0;
		cur_next.prefix = 1'b0;
		cur_next.res_valid = 1'b0;
		cur_next.fetch_next = op_valid_i; // RULE_20
		if (dead_bus_cycle_i) begin
			cur_next.bus_addr = DEAD_ADDR; // RULE_21
			cur_next.bus_rw = 1'b1;
			cur_next.bus_status = 1'b0;
		end else begin
			cur_next.bus_addr = fetch_addr_i;
			cur_next.bus_rw = 1'b1;
			cur_next.bus_status = bus_status_line_i;
		end
		if (op_valid_i) begin
			case (cur_reg.st)
				ST_OP1: begin
					if (op_byte_i == OP_PAGE2 || op_byte_i == OP_PAGE3) begin
						cur_next.prefix = 1'b1; // RULE_02
						cur_next.st = (op_byte_i == OP_PAGE2) ? ST_PG2 : ST_PG3;
					end else begin
						info = lookup_p1(op_byte_i);
						cur_next.dec_valid = 1'b1;
					end
				end
				ST_PG2, ST_PG3: begin
					if (op_byte_i == OP_PAGE2 || op_byte_i == OP_PAGE3) begin
						cur_next.prefix = 1'b1;
					end else begin
						paged = 1'b1;
						info = lookup_pg(cur_reg.st == ST_PG3, op_byte_i);
						cur_next.dec_valid = 1'b1;
						cur_next.st = ST_OP1;
					end
				end
				default: cur_next.st = ST_OP1;
			endcase
		end
		if (cur_next.dec_valid) begin
			cur_next.illegal = ~info.legal; // RULE_01
			cur_next.mode = info.mode; // RULE_23
			cur_next.base_cyc = info.cyc;
			cur_next.branch = info.legal & (info.mode == MD_REL);
			cur_next.long_br = info.legal & paged & (info.mode == MD_REL);
			cur_next.taken = 1'b0;
			if (op_byte_i[7:4] == ROW_BRANCH && info.legal)
				cur_next.taken = cif.taken; // RULE_10
			else if (cur_next.branch)
				cur_next.taken = 1'b1;
			cur_next.stack_op = ~paged & (op_byte_i >= OP_PUSH_HW) &
				(op_byte_i <= OP_PULL_USR);
			cur_next.stack_push = ~op_byte_i[0]; // RULE_05 RULE_06
			cur_next.stack_user = op_byte_i[1];
			cur_next.set_masks = ~paged & (op_byte_i == OP_SOFT_INT); // RULE_18
			cur_next.h_undef = ~paged & info.legal &
				(((op_byte_i[3:0] == LO_NEGATE) & ~op_byte_i[7] &
				(op_byte_i[7:4] != ROW_BRANCH) &
				(op_byte_i[7:4] != ROW_STACK) &
				(op_byte_i[7:4] != ROW_MISC)) |
				(op_byte_i[7] & ((op_byte_i[3:0] == LO_NEGATE) |
				(op_byte_i[3:0] == LO_SBC)))); // RULE_16
			cur_next.pair_bad = ~paged &
				((op_byte_i == OP_XCHG) | (op_byte_i == OP_XFER)) &
				((pair_class(post_byte_i[7:4]) == 2'h0) |
				(pair_class(post_byte_i[7:4]) !=
				pair_class(post_byte_i[3:0]))); // RULE_17
			if (info.mode == MD_IDX)
				add = CYC_W'(idx_extra_cyc_i); // RULE_03
			else if (cur_next.stack_op)
				add = CYC_W'(stack_bytes(post_byte_i)); // RULE_04
			else if (cur_next.long_br && cur_next.taken &&
				op_byte_i != OP_BR_NEVER)
				add = CYC_W'(CYC_TAKEN_ADD); // RULE_08
			cur_next.cycles = CYC_W'(info.cyc) + add;
			cur_next.len = (info.mode == MD_IDX) ?
				info.len + idx_extra_len_i : info.len; // RULE_03
			if (!paged && op_byte_i == OP_UMULT) begin
				cur_next.res_valid = 1'b1;
				cur_next.res_d = prod;
				cur_next.res_carry = prod[7]; // RULE_15
			end else if (!paged && op_byte_i == OP_SIGN_EXT) begin
				cur_next.res_valid = 1'b1;
				cur_next.res_d = {{8{acc_b_i[7]}}, acc_b_i}; // RULE_19
				cur_next.res_carry = cond_code_reg_i[CC_C];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cur_reg <= '0;
			cur_reg.st <= ST_OP1;
			cur_reg.bus_addr <= DEAD_ADDR;
			cur_reg.bus_rw <= 1'b1;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dec_valid_o = cur_reg.dec_valid;
	assign illegal_o = cur_reg.illegal;
	assign prefix_o = cur_reg.prefix;
	assign mode_o = cur_reg.mode;
	assign total_len_o = cur_reg.len;
	assign total_cycles_o = cur_reg.cycles;
	assign base_cycles_o = cur_reg.base_cyc;
	assign branch_o = cur_reg.branch;
	assign branch_taken_o = cur_reg.taken;
	assign long_branch_o = cur_reg.long_br;
	assign stack_op_o = cur_reg.stack_op;
	assign stack_push_o = cur_reg.stack_push;
	assign stack_user_o = cur_reg.stack_user;
	assign set_irq_masks_o = cur_reg.set_masks;
	assign half_carry_undef_o = cur_reg.h_undef;
	assign reg_pair_bad_o = cur_reg.pair_bad;
	assign result_valid_o = cur_reg.res_valid;
	assign result_d_o = cur_reg.res_d;
	assign result_carry_o = cur_reg.res_carry;
	assign fetch_next_o = cur_reg.fetch_next;
	assign bus_addr_o = cur_reg.bus_addr;
	assign bus_rw_o = cur_reg.bus_rw;
	assign bus_status_line_o = cur_reg.bus_status;

endmodule

// file: dv/cpudec_monitor.sv
// property checker for the opcode decode block
`timescale 1ns/1ps
module cpudec_monitor
	import cpudec_pkg::*;
(
	// inputs
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic op_valid_i,
	input wire logic [7:0] op_byte_i,
	input wire logic [7:0] post_byte_i,
	input wire logic [7:0] acc_a_i,
	input wire logic [7:0] acc_b_i,
	input wire logic dead_bus_cycle_i,
	// outputs
	input wire logic prefix_o,
	input wire logic [LEN_W-1:0] total_len_o,
	input wire logic [CYC_W-1:0] total_cycles_o,
	input wire logic branch_taken_o,
	input wire logic stack_push_o,
	input wire logic set_irq_masks_o,
	input wire logic [15:0] result_d_o,
	input wire logic result_carry_o,
	input wire logic fetch_next_o,
	input wire logic [15:0] bus_addr_o,
	input wire logic bus_rw_o,
	input wire logic bus_status_line_o
);
	// page of the next byte: 0 first, 1 second, 2 third
	logic [1:0] pg_reg;
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			pg_reg <= 2'h0;
		else if (op_valid_i)
			pg_reg <= (op_byte_i[7:1] != 7'h08) ? 2'h0 :
				(pg_reg != 2'h0) ? pg_reg : {op_byte_i[0], ~op_byte_i[0]};
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	a_prefix_taken: assert property (op_valid_i && op_byte_i[7:1] == 7'h08
		|=> prefix_o) else $error("prefix byte not taken");
	a_short_branch: assert property (op_valid_i && pg_reg == 2'h0 &&
		op_byte_i[7:4] == 4'h2 |=> total_len_o == 4'h2 && total_cycles_o == 6'h03)
		else $error("short branch counts wrong");
	a_long_branch: assert property (op_valid_i && pg_reg == 2'h1 &&
		op_byte_i[7:4] == 4'h2 && op_byte_i[3:1] != 3'h0 |=> total_len_o == 4'h4
		&& total_cycles_o == 6'h05 + branch_taken_o) else $error("long branch");
	a_stack_count: assert property (op_valid_i && pg_reg == 2'h0 &&
		op_byte_i[7:2] == 6'h0d |=> total_cycles_o == 5 + 2 *
		$countones($past(post_byte_i[7:4])) + $countones($past(post_byte_i[3:0]))
		&& stack_push_o == !$past(op_byte_i[0])) else $error("stack count");
	a_mult_result: assert property (op_valid_i && pg_reg == 2'h0 &&
		op_byte_i == 8'h3d |=> result_d_o == $past(acc_a_i) * $past(acc_b_i)
		&& result_carry_o == result_d_o[7]) else $error("multiply result");
	a_sign_extend: assert property (op_valid_i && pg_reg == 2'h0 &&
		op_byte_i == 8'h1d |=> result_d_o == {{8{$past(acc_b_i[7])}},
		$past(acc_b_i)}) else $error("sign extend");
	a_soft_masks: assert property (op_valid_i && op_byte_i == 8'h3f
		|=> set_irq_masks_o == ($past(pg_reg) == 2'h0)) else $error("masks");
	a_dead_cycle: assert property (dead_bus_cycle_i |=> bus_addr_o == 16'hffff
		&& bus_rw_o && !bus_status_line_o) else $error("dead cycle bus");
	a_fetch_next: assert property (op_valid_i |=> fetch_next_o)
		else $error("next byte not fetched");
endmodule

// file: dv/cpudec_fetch_model.sv
// fetch sequencer model feeding opcode bytes
`timescale 1ns/1ps
module cpudec_fetch_model (
	input wire logic mclk_i,
	output logic op_valid_o,
	output logic [7:0] op_byte_o,
	output logic [7:0] post_byte_o
);
	initial begin
		op_valid_o = 1'b0;
		op_byte_o = 8'h12;
		post_byte_o = 8'h00;
	end
	task send(input logic [7:0] op, input logic [7:0] pb);
		@(posedge mclk_i);
		op_valid_o <= 1'b1;
		op_byte_o <= op;
		post_byte_o <= pb;
	endtask
	// stale bytes are scrambled once the fetch is withdrawn
	task idle;
		@(posedge mclk_i);
		op_valid_o <= 1'b0;
		op_byte_o <= ~op_byte_o;
		post_byte_o <= ~post_byte_o;
	endtask
endmodule

// file: dv/cpudec_top_tb.sv
// self-checking bench for the opcode decode block
`timescale 1ns/1ps
module cpudec_top_tb;
	import cpudec_pkg::*;
	logic mclk_i, sys_rst_i, op_valid_i, dead_bus_cycle_i, dec_valid_o;
	logic illegal_o, branch_taken_o, stack_push_o, stack_user_o;
	logic set_irq_masks_o, result_carry_o, bus_rw_o, bus_status_line_o;
	logic prefix_o, fetch_next_o;
	logic branch_o, long_branch_o, stack_op_o, half_carry_undef_o;
	logic reg_pair_bad_o, result_valid_o;
	logic [3:0] idx_extra_cyc_i, idx_extra_len_i;
	cpudec_mode_t mode_o;
	logic [7:0] op_byte_i, post_byte_i, cond_code_reg_i, acc_a_i, acc_b_i;
	logic [3:0] total_len_o;
	logic [5:0] total_cycles_o;
	logic [4:0] base_cycles_o;
	logic [15:0] result_d_o, bus_addr_o;
	int failures = 0;
	int tests_run = 0;
	cpudec_fetch_model u_cpudec_fetch_model (.mclk_i(mclk_i),
		.op_valid_o(op_valid_i), .op_byte_o(op_byte_i), .post_byte_o(post_byte_i));
	cpudec_top u_cpudec_top (.*, .fetch_addr_i(16'h8000),
		.bus_status_line_i(1'b1));
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic cond_exp(input logic [3:0] o, input logic [3:0] f);
		logic [7:0] t;
		t = {~f[2] & (f[3] ~^ f[1]), f[3] ~^ f[1], ~f[3], ~f[1], ~f[2], ~f[0],
			~(f[0] | f[2]), 1'b1};
		return t[o[3:1]] ^ o[0];
	endfunction
	task dec(input logic [7:0] op, input logic [7:0] pb);
		u_cpudec_fetch_model.send(op, pb);
		u_cpudec_fetch_model.idle();
		#1;
		chk("dec valid", dec_valid_o, 1'b1);
	endtask
	task sc_branches;
		logic e;
		for (int o = 2; o < 16; o++) for (int f = 0; f < 16; f++) begin
			e = cond_exp(o[3:0], f[3:0]);
			@(posedge mclk_i) cond_code_reg_i <= f[7:0];
			dec({4'h2, o[3:0]}, 8'h00);
			chk("short taken", branch_taken_o, e);
			chk("short size", {total_len_o, total_cycles_o}, 10'h083);
			chk("short kind", {mode_o, branch_o, long_branch_o},
				{MD_REL, 2'h2});
			u_cpudec_fetch_model.send(OP_PAGE2, 8'h00);
			dec({4'h2, o[3:0]}, 8'h00);
			chk("long taken", branch_taken_o, e);
			chk("long size", {total_len_o, total_cycles_o}, {4'h4, 6'h05 + e});
			chk("long kind", {mode_o, branch_o, long_branch_o},
				{MD_REL, 2'h3});
		end
	endtask
	task sc_stack;
		logic [7:0] op;
		for (int i = 0; i < 8; i++) begin
			op = 8'h34 + {6'h0, i[2:1]};
			dec(op, i[0] ? 8'hff : 8'h81);
			chk("stack", {stack_op_o, total_len_o, total_cycles_o, stack_push_o,
				stack_user_o},
				{1'b1, 4'h2, i[0] ? 6'h11 : 6'h08, ~op[0], op[1]});
		end
	endtask
	task sc_special;
		@(posedge mclk_i) acc_a_i <= 8'h0c;
		acc_b_i <= 8'h0b;
		dec(OP_UMULT, 8'h00);
		chk("mult", {result_valid_o, result_d_o, result_carry_o},
			18'h20109);
		chk("mult size", {total_len_o, total_cycles_o}, 10'h04b);
		@(posedge mclk_i) acc_a_i <= 8'hff;
		acc_b_i <= 8'hff;
		dec(OP_UMULT, 8'h00);
		chk("mult2", {result_valid_o, result_d_o, result_carry_o},
			18'h3fc02);
		@(posedge mclk_i) acc_b_i <= 8'h80;
		dec(OP_SIGN_EXT, 8'h00);
		chk("sext", result_d_o, 16'hff80);
		chk("sext size", {total_len_o, total_cycles_o}, 10'h042);
	endtask
	task sc_misc;
		dec(8'h01, 8'h00);
		chk("unused", illegal_o, 1'b1);
		u_cpudec_fetch_model.send(OP_PAGE2, 8'h00);
		dec(8'h20, 8'h00);
		chk("page2 unused", illegal_o, 1'b1);
		dec(OP_LONG_CALL, 8'h00);
		chk("long call", {total_len_o, base_cycles_o}, 9'h069);
		dec(8'h8d, 8'h00);
		chk("short call", {total_len_o, base_cycles_o}, 9'h047);
		dec(OP_SOFT_INT, 8'h00);
		chk("soft one", set_irq_masks_o, 1'b1);
		u_cpudec_fetch_model.send(OP_PAGE2, 8'h00);
		u_cpudec_fetch_model.send(OP_PAGE3, 8'h00);
		dec(OP_SOFT_INT, 8'h00);
		chk("soft two", set_irq_masks_o, 1'b0);
		@(posedge mclk_i) dead_bus_cycle_i <= 1'b1;
		@(posedge mclk_i) dead_bus_cycle_i <= 1'b0;
		#1 chk("dead", {bus_addr_o, bus_rw_o}, 17'h1ffff);
		chk("dead status", bus_status_line_o, 1'b0);
		@(posedge mclk_i);
		#1 chk("live", {bus_addr_o, bus_status_line_o}, 17'h10001);
	endtask
	task sc_table;
		dec(8'ha0, 8'h00);
		chk("indexed", {mode_o, total_len_o, total_cycles_o, half_carry_undef_o},
			{MD_IDX, 4'h4, 6'h07, 1'b1});
		dec(8'hb3, 8'h00);
		chk("extended", {mode_o, total_len_o, total_cycles_o, half_carry_undef_o},
			{MD_EXT, 4'h3, 6'h07, 1'b0});
		dec(8'h8e, 8'h00);
		chk("immediate", {mode_o, total_len_o, total_cycles_o},
			{MD_IMM, 10'h0c3});
		dec(OP_XFER, 8'h89);
		chk("pair ok", {reg_pair_bad_o, total_cycles_o}, 7'h06);
		dec(OP_XFER, 8'h18);
		chk("pair bad", reg_pair_bad_o, 1'b1);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		sys_rst_i = 1'b1;
		dead_bus_cycle_i = 1'b0;
		cond_code_reg_i = 8'h00;
		acc_a_i = 8'h00;
		acc_b_i = 8'h00;
		idx_extra_cyc_i = 4'h3;
		idx_extra_len_i = 4'h2;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		sc_branches();
		sc_stack();
		sc_special();
		sc_misc();
		sc_table();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		failures++;
		print_verdict();
	end
endmodule
bind cpudec_top cpudec_monitor u_cpudec_monitor (.*);
